// ### verilog/mgmt_mode_pkg.sv
// Constants for the management-mode context save and restore block
package mgmt_mode_pkg;
  localparam logic [31:0] MGMT_BASE_RST   = 32'h0003_0000;
  localparam logic [31:0] AREA_OFS        = 32'h0000_8000;
  localparam int          SLOT_COUNT      = 66;
  localparam int          ALIGN_BITS      = 15;
  localparam logic [15:0] RESUME_OPCODE   = 16'h0faa;
  // Arbitrary neutral value, not tied to any real part
  localparam logic [31:0] REVISION_ID     = 32'h0003_0001;
  // Image slot offsets, relative to base plus AREA_OFS
  localparam logic [15:0] CTRL_REG_ZERO_IMAGE_OFS      = 16'h7ffc;
  localparam logic [15:0] PAGE_DIR_BASE_IMAGE_OFS      = 16'h7ff8;
  localparam logic [15:0] FLAGS_IMAGE_OFS              = 16'h7ff4;
  localparam logic [15:0] INSTR_PTR_IMAGE_OFS          = 16'h7ff0;
  localparam logic [15:0] DST_INDEX_IMAGE_OFS          = 16'h7fec;
  localparam logic [15:0] SRC_INDEX_IMAGE_OFS          = 16'h7fe8;
  localparam logic [15:0] FRAME_PTR_IMAGE_OFS          = 16'h7fe4;
  localparam logic [15:0] STACK_PTR_IMAGE_OFS          = 16'h7fe0;
  localparam logic [15:0] GPR_B_IMAGE_OFS              = 16'h7fdc;
  localparam logic [15:0] GPR_D_IMAGE_OFS              = 16'h7fd8;
  localparam logic [15:0] GPR_C_IMAGE_OFS              = 16'h7fd4;
  localparam logic [15:0] GPR_A_IMAGE_OFS              = 16'h7fd0;
  localparam logic [15:0] DEBUG_STATUS_IMAGE_OFS       = 16'h7fcc;
  localparam logic [15:0] DEBUG_CONTROL_IMAGE_OFS      = 16'h7fc8;
  localparam logic [15:0] TASK_SELECTOR_IMAGE_OFS      = 16'h7fc4;
  localparam logic [15:0] LOCAL_TABLE_SELECTOR_IMAGE_OFS = 16'h7fc0;
  localparam logic [15:0] G_SEG_SELECTOR_IMAGE_OFS     = 16'h7fbc;
  localparam logic [15:0] F_SEG_SELECTOR_IMAGE_OFS     = 16'h7fb8;
  localparam logic [15:0] DATA_SEG_SELECTOR_IMAGE_OFS  = 16'h7fb4;
  localparam logic [15:0] STACK_SEG_SELECTOR_IMAGE_OFS = 16'h7fb0;
  localparam logic [15:0] CODE_SEG_SELECTOR_IMAGE_OFS  = 16'h7fac;
  localparam logic [15:0] EXTRA_SEG_SELECTOR_IMAGE_OFS = 16'h7fa8;
  localparam logic [15:0] INTERRUPT_TABLE_BASE_IMAGE_OFS = 16'h7f94;
  localparam logic [15:0] GLOBAL_TABLE_BASE_IMAGE_OFS  = 16'h7f88;
  localparam logic [15:0] IO_TRAP_INFO_WORD_OFS        = 16'h7f04;
  localparam logic [15:0] HALT_RESUME_SLOT_OFS         = 16'h7f02;
  localparam logic [15:0] IO_REEXECUTE_SLOT_OFS        = 16'h7f00;
  localparam logic [15:0] FEATURE_REVISION_SLOT_OFS    = 16'h7efc;
  localparam logic [15:0] SAVE_AREA_BASE_SLOT_OFS      = 16'h7ef8;
  // Control register zero bit positions
  localparam int PAGING_ON_BIT       = 31;
  localparam int CACHE_DISABLE_BIT   = 30;
  localparam int NO_WRITETHROUGH_BIT = 29;
  localparam int PROTECTION_ON_BIT   = 0;
  // Bit positions inside the 7F00h word
  localparam int HALT_RESUME_BIT     = 16;
  localparam int IO_REEXECUTE_BIT    = 0;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_DRAIN   = 3'b001,
    ST_SAVE    = 3'b010,
    ST_HANDLER = 3'b011,
    ST_RESTORE = 3'b100,
    ST_SHUT    = 3'b101
  } mgmt_state_t;
endpackage : mgmt_mode_pkg

// ### verilog/mgmt_mode_context_save.sv
// Management-mode entry, context save image, resume checks and restore
//
// Contract
// RQ1: Memory controller decodes 38000h-3FFFFh as management RAM while strobe active.
// RQ2: Memory controller may decode a larger region, 32 Kbytes to 4 Gbytes.
// RQ3: Overlaid RAM systems assert cache flush with the interrupt request.
// RQ4: Other masters hitting management range during strobe go to system RAM.
// RQ5: System offers a manual mapping of management RAM outside the mode.
// RQ6: Strobe goes low before any save write.
// RQ7: Image top is base plus 8000h plus 7FFFh; base resets to 30000h.
// RQ8: Default image spans 3FFFFh to 3FE00h; handler starts at 38000h. The code writes 66 words, so its image ends at 3FEF8h.
// RQ9: Each slot lands at base plus 8000h plus its offset.
// RQ10: Selector slots 7FC4h..7FA8h write only the low half.
// RQ11: Resume reloads slots from memory so handler edits take effect.
// RQ12: Hidden state goes into the reserved ranges of the image.
// RQ13: Test registers and floating-point state are not saved or restored.
// RQ14: Opcode 0F AAh is the resume instruction.
// RQ15: Resume outside the mode raises invalid opcode.
// RQ16: Misaligned base or illegal control bits on resume cause shutdown.
// RQ17: Shutdown issues a shutdown cycle and waits for NMI or reset.
// RQ18: Halt slot chooses between re-entering halt and continuing after it.
// RQ19: I/O slot set by handler makes resume re-execute trapped I/O.
// RQ20: Resume loads the base from the relocation slot, 32-Kbyte aligned.
// RQ21: Reset leaves the mode and releases the strobe.
// RQ22: Strobe asserts after write buffers drain, held to last restore read.
// RQ23: Requests masked in the mode; at most one stays pending.
// RQ24: Requester holds the input inactive four clocks between requests.
// RQ25: Handler begins at base plus 8000h.
// RQ26: Image written as descending 32-bit words, read back in fixed order.
`timescale 1ns/1ps
`default_nettype none
module mgmt_mode_context_save (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        mgmt_irq_n,
  output logic             mgmt_active_n,
  input  wire logic        instr_boundary,
  input  wire logic        write_buf_empty,
  input  wire logic        core_halted,
  input  wire logic        nmi,
  output logic [6:0]       ctx_slot_idx,
  input  wire logic [31:0] ctx_slot_data,
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [3:0]       mem_be,
  output logic [31:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  output logic             handler_start,
  output logic [31:0]      handler_addr,
  input  wire logic        opcode_valid,
  input  wire logic [15:0] opcode,
  output logic             invalid_opcode,
  output logic             restore_valid,
  output logic [15:0]      restore_ofs,
  output logic [31:0]      restore_data,
  output logic             resume_done,
  output logic             resume_to_halt,
  output logic             io_reexecute,
  output logic             shutdown_cycle,
  output logic             in_shutdown,
  output logic             in_mgmt_mode,
  output logic [31:0]      mgmt_base
);
  import mgmt_mode_pkg::*;

  // Slot offset of image word idx, descending from the top word
  function automatic logic [15:0] slot_ofs(input logic [6:0] idx);
    slot_ofs = CTRL_REG_ZERO_IMAGE_OFS - {7'h00, idx, 2'b00};
  endfunction : slot_ofs

  function automatic logic is_selector(input logic [15:0] ofs);
    is_selector = (ofs <= TASK_SELECTOR_IMAGE_OFS) && (ofs >= EXTRA_SEG_SELECTOR_IMAGE_OFS);
  endfunction : is_selector

  mgmt_state_t state_q;
  logic [6:0]  idx_q;
  logic        irq_prev_q;
  logic        pending_q;
  logic        active_q;
  logic        halted_q;
  logic [31:0] base_q;
  logic [31:0] cr0_img_q;
  logic [31:0] ctl_img_q;
  logic        start_q;
  logic        inval_q;
  logic        rvalid_q;
  logic [15:0] rofs_q;
  logic [31:0] rdata_q;
  logic        done_q;
  logic        shut_q;
  logic        halt_out_q;
  logic        io_out_q;

  logic [15:0] cur_ofs;
  logic        irq_edge;
  logic        take;
  logic        last_slot;
  logic        ack_save;
  logic        ack_rest;
  logic        resume_hit;
  logic        cr0_bad;
  logic        image_bad;

  assign cur_ofs    = slot_ofs(idx_q);
  assign irq_edge   = irq_prev_q && !mgmt_irq_n;
  assign take       = (state_q == ST_IDLE) && pending_q && instr_boundary;
  assign last_slot  = (idx_q == 7'(SLOT_COUNT - 1));
  assign ack_save   = (state_q == ST_SAVE) && mem_ack;
  assign ack_rest   = (state_q == ST_RESTORE) && mem_ack;
  assign resume_hit = opcode_valid && (opcode == RESUME_OPCODE); // RQ14
  // Control register zero is slot 0, so it is already captured by the last read
  assign cr0_bad    = (cr0_img_q[PAGING_ON_BIT] && !cr0_img_q[PROTECTION_ON_BIT]) ||
                      (cr0_img_q[NO_WRITETHROUGH_BIT] && !cr0_img_q[CACHE_DISABLE_BIT]);
  assign image_bad  = cr0_bad || (mem_rdata[ALIGN_BITS-1:0] != '0); // RQ16 RQ20

  // Request edge capture; a new edge wins over the clear on service
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_prev_q <= 1'b1;
      pending_q  <= 1'b0;
    end else begin
      irq_prev_q <= mgmt_irq_n;
      pending_q  <= irq_edge || (pending_q && !take); // RQ23
    end
  end

  // Mode sequencer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= ST_IDLE; // RQ21
      idx_q   <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          idx_q <= '0;
          if (take) begin
            state_q <= ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          if (write_buf_empty) begin
            state_q <= ST_SAVE; // RQ22
          end
        end
        ST_SAVE: begin
          if (mem_ack) begin
            idx_q <= last_slot ? '0 : idx_q + 7'd1; // RQ26
            if (last_slot) begin
              state_q <= ST_HANDLER;
            end
          end
        end
        ST_HANDLER: begin
          if (resume_hit) begin
            state_q <= ST_RESTORE;
          end
        end
        ST_RESTORE: begin
          if (mem_ack) begin
            idx_q <= last_slot ? '0 : idx_q + 7'd1; // RQ11 RQ26
            if (last_slot) begin
              state_q <= image_bad ? ST_SHUT : ST_IDLE; // RQ16
            end
          end
        end
        ST_SHUT: begin
          if (nmi) begin
            state_q <= ST_IDLE; // RQ17
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Active strobe: low from drained buffers until the last restore read
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      active_q <= 1'b0; // RQ21
    end else if (state_q == ST_DRAIN && write_buf_empty) begin
      active_q <= 1'b1; // RQ6 RQ22
    end else if (ack_rest && last_slot) begin
      active_q <= 1'b0; // RQ22
    end
  end

  // Base register, halted flag and restore captures
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      base_q    <= MGMT_BASE_RST; // RQ7
      halted_q  <= 1'b0;
      cr0_img_q <= '0;
      ctl_img_q <= '0;
    end else begin
      if (take) begin
        halted_q <= core_halted;
      end
      if (ack_rest && cur_ofs == CTRL_REG_ZERO_IMAGE_OFS) begin
        cr0_img_q <= mem_rdata;
      end
      if (ack_rest && cur_ofs == IO_REEXECUTE_SLOT_OFS) begin
        ctl_img_q <= mem_rdata;
      end
      if (ack_rest && last_slot && !image_bad) begin
        base_q <= mem_rdata; // RQ20
      end
    end
  end

  // Pulses and registered result outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      start_q    <= 1'b0;
      inval_q    <= 1'b0;
      rvalid_q   <= 1'b0;
      rofs_q     <= '0;
      rdata_q    <= '0;
      done_q     <= 1'b0;
      shut_q     <= 1'b0;
      halt_out_q <= 1'b0;
      io_out_q   <= 1'b0;
    end else begin
      start_q  <= ack_save && last_slot; // RQ25
      inval_q  <= resume_hit && (state_q != ST_HANDLER); // RQ15
      rvalid_q <= ack_rest; // RQ11
      done_q   <= ack_rest && last_slot && !image_bad;
      shut_q   <= ack_rest && last_slot && image_bad; // RQ17
      if (ack_rest) begin
        rofs_q  <= cur_ofs;
        rdata_q <= mem_rdata;
      end
      if (ack_rest && last_slot) begin
        halt_out_q <= halted_q && ctl_img_q[HALT_RESUME_BIT]; // RQ18
        io_out_q   <= ctl_img_q[IO_REEXECUTE_BIT]; // RQ19
      end
    end
  end

  // Save word content; core supplies plain registers and hidden state by index
  always_comb begin
    ctx_slot_idx = idx_q;
    mem_wdata    = ctx_slot_data; // RQ12 RQ13
    mem_be       = 4'hf;
    if (cur_ofs == SAVE_AREA_BASE_SLOT_OFS) begin
      mem_wdata = base_q;
    end else if (cur_ofs == FEATURE_REVISION_SLOT_OFS) begin
      mem_wdata = REVISION_ID;
    end else if (cur_ofs == IO_REEXECUTE_SLOT_OFS) begin
      // Halt slot defaults to the halted flag (re-enter halt only if halted), I/O slot defaults to clear
      mem_wdata = '0;
      mem_wdata[HALT_RESUME_BIT] = halted_q;
    end else if (is_selector(cur_ofs)) begin
      mem_be = 4'h3; // RQ10
    end
  end

  assign mem_req        = (state_q == ST_SAVE) || (state_q == ST_RESTORE);
  assign mem_we         = (state_q == ST_SAVE);
  assign mem_addr       = base_q + AREA_OFS + {16'h0000, cur_ofs}; // RQ7 RQ8 RQ9
  assign mgmt_active_n  = !active_q;
  assign handler_start  = start_q;
  assign handler_addr   = base_q + AREA_OFS; // RQ8 RQ25
  assign invalid_opcode = inval_q;
  assign restore_valid  = rvalid_q;
  assign restore_ofs    = rofs_q;
  assign restore_data   = rdata_q;
  assign resume_done    = done_q;
  assign resume_to_halt = halt_out_q;
  assign io_reexecute   = io_out_q;
  assign shutdown_cycle = shut_q;
  assign in_shutdown    = (state_q == ST_SHUT);
  assign in_mgmt_mode   = (state_q != ST_IDLE) && (state_q != ST_SHUT);
  assign mgmt_base      = base_q;

  a_strobe_before_save: assert property (@(posedge sys_clk) disable iff (rst) // RQ6
    (mem_req && mem_we) |-> !mgmt_active_n)
    else $error("save write issued while strobe inactive");

  a_strobe_held_restore: assert property (@(posedge sys_clk) disable iff (rst) // RQ22
    (state_q == ST_RESTORE) |-> !mgmt_active_n)
    else $error("strobe released before last restore read");

  a_image_top_addr: assert property (@(posedge sys_clk) disable iff (rst) // RQ7
    (mem_req && mem_we && idx_q == '0) |-> mem_addr == base_q + 32'h0000_fffc)
    else $error("first save word not at top of image");

  a_selector_low_half: assert property (@(posedge sys_clk) disable iff (rst) // RQ10
    (mem_we && mem_req && cur_ofs <= 16'h7fc4 && cur_ofs >= 16'h7fa8) |-> mem_be == 4'h3)
    else $error("selector slot wrote upper bytes");

  a_handler_entry: assert property (@(posedge sys_clk) disable iff (rst) // RQ25
    (ack_save && last_slot) |=> handler_start && handler_addr == base_q + 32'h0000_8000)
    else $error("handler not started at base plus 8000h");

  a_resume_outside: assert property (@(posedge sys_clk) disable iff (rst) // RQ15
    (resume_hit && state_q == ST_IDLE) |=> invalid_opcode && state_q != ST_RESTORE)
    else $error("resume outside the mode not refused");

  a_bad_image_shutdown: assert property (@(posedge sys_clk) disable iff (rst) // RQ16
    (ack_rest && last_slot && mem_rdata[14:0] != 15'h0000) |=> shutdown_cycle ##1 in_shutdown)
    else $error("misaligned base did not shut down");

  a_base_reload: assert property (@(posedge sys_clk) disable iff (rst) // RQ20
    resume_done |-> mgmt_base == $past(mem_rdata) && mgmt_base[14:0] == 15'h0000)
    else $error("base not reloaded from relocation slot");

  a_request_masked: assert property (@(posedge sys_clk) disable iff (rst) // RQ23
    (state_q == ST_HANDLER && irq_edge) |=> pending_q && state_q != ST_DRAIN)
    else $error("request not held pending while in the mode");

  a_reset_exit: assert property (@(posedge sys_clk) // RQ21
    $past(rst) |-> mgmt_active_n && !in_mgmt_mode)
    else $error("reset did not leave the mode");

  a_save_descending: assert property (@(posedge sys_clk) disable iff (rst) // RQ26
    (ack_save && !last_slot) |=> mem_addr == $past(mem_addr) - 32'h0000_0004)
    else $error("save words not in descending order");

  a_restore_forward: assert property (@(posedge sys_clk) disable iff (rst) // RQ11
    ack_rest |=> restore_valid && restore_data == $past(mem_rdata))
    else $error("restore word not handed to the core");

  a_strobe_waits_drain: assert property (@(posedge sys_clk) disable iff (rst) // RQ22
    (state_q == ST_DRAIN && !write_buf_empty) |=> mgmt_active_n)
    else $error("strobe asserted before write buffers drained");

  a_halt_slot_default: assert property (@(posedge sys_clk) disable iff (rst) // RQ18 RQ19
    (mem_req && mem_we && cur_ofs == IO_REEXECUTE_SLOT_OFS) |->
      mem_wdata[HALT_RESUME_BIT] == halted_q && !mem_wdata[IO_REEXECUTE_BIT])
    else $error("restart slots not saved with their defaults");

  a_no_reentry: assert property (@(posedge sys_clk) disable iff (rst) // RQ23
    (state_q == ST_HANDLER) |=> (state_q == ST_HANDLER) || (state_q == ST_RESTORE))
    else $error("mode re-entered before resume");

  a_shutdown_hold: assert property (@(posedge sys_clk) disable iff (rst) // RQ17
    (in_shutdown && !nmi) |=> in_shutdown)
    else $error("shutdown left without nmi or reset");

  c_save_done:    cover property (@(posedge sys_clk) disable iff (rst) handler_start);
  c_resume_ok:    cover property (@(posedge sys_clk) disable iff (rst) resume_done);
  c_shutdown:     cover property (@(posedge sys_clk) disable iff (rst) shutdown_cycle);
  c_back_to_back: cover property (@(posedge sys_clk) disable iff (rst) resume_done && pending_q);
endmodule : mgmt_mode_context_save
`default_nettype wire

// ### bench/mem_ctrl_model.sv
// Behavioural system memory controller that decodes management RAM
`timescale 1ns/1ps
`default_nettype none
module mem_ctrl_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        mgmt_active_n,
  input  wire logic [1:0]  wait_cycles,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [3:0]  mem_be,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata,
  output int               stray_count
);
  logic [31:0] mem [int unsigned];
  logic [31:0] w_v;
  logic [1:0]  cnt_q;
  task automatic poke(input logic [31:0] a, input logic [31:0] d);
    mem[a[31:2]] = d;
  endtask : poke
  function automatic logic [31:0] peek(input logic [31:0] a);
    return mem.exists(a[31:2]) ? mem[a[31:2]] : 32'h0;
  endfunction : peek
  initial stray_count = 0;
  always @(posedge sys_clk) begin
    if (rst) begin
      mem_ack <= 1'b0;
      cnt_q <= 2'h0;
      mem_rdata <= 32'h0;
    end else if (mem_req && !mem_ack && cnt_q != wait_cycles) begin
      cnt_q <= cnt_q + 2'h1;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req && !mem_ack) begin
      mem_ack <= 1'b1;
      cnt_q <= 2'h0;
      // Any address is management RAM, but only while the strobe is low
      if (mgmt_active_n) stray_count <= stray_count + 1;
      else if (mem_we) begin
        w_v = peek(mem_addr);
        for (int b = 0; b < 4; b++) if (mem_be[b]) w_v[8*b+:8] = mem_wdata[8*b+:8];
        mem[mem_addr[31:2]] = w_v;
      end else mem_rdata <= peek(mem_addr);
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : mem_ctrl_model
`default_nettype wire

// ### bench/mgmt_mode_context_save_tb.sv
// Self-checking bench for the management-mode context save block
`timescale 1ns/1ps
`default_nettype none
module mgmt_mode_context_save_tb;
  import mgmt_mode_pkg::*;
  typedef struct {logic [15:0] ofs; logic [31:0] exp;} row_t;
  logic        sys_clk, rst, mgmt_irq_n, mgmt_active_n, instr_boundary, write_buf_empty, core_halted, nmi;
  logic        mem_req, mem_we, mem_ack, handler_start, opcode_valid, invalid_opcode, restore_valid;
  logic        resume_done, resume_to_halt, io_reexecute, shutdown_cycle, in_shutdown, in_mgmt_mode;
  logic        cache_flush;
  logic [1:0]  wait_cycles;
  logic [3:0]  mem_be, seen;
  logic [6:0]  ctx_slot_idx;
  logic [15:0] opcode, restore_ofs;
  logic [31:0] ctx_slot_data, mem_addr, mem_wdata, mem_rdata, handler_addr, restore_data, mgmt_base, got_a;
  int          bad_count, checks_done, stray_count, flush_skew;
  row_t        rows [8] = '{'{16'h7ffc, 32'h05c3_0000}, '{16'h7fd0, 32'h05c3_000b},
    '{16'h7fc4, 32'hffff_000e}, '{16'h7fa8, 32'hffff_0015}, '{16'h7f98, 32'h05c3_0019},
    '{16'h7f00, 32'h0001_0000}, '{16'h7efc, REVISION_ID}, '{16'h7ef8, 32'h0003_0000}};
  logic [31:0] bad_img [3][2] = '{'{32'h8000_0000, 32'h0004_0000}, '{32'h2000_0000, 32'h0004_0000},
    '{32'h0000_0000, 32'h0004_4000}};

  // Core side: each image word carries its own index
  assign ctx_slot_data = {16'h05c3, 9'h0, ctx_slot_idx};
  mgmt_mode_context_save mgmt_mode_context_save_i (.*);
  mem_ctrl_model mem_ctrl_model_i (.*);

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Registered pulses are caught here so no wait can miss one
  always @(posedge sys_clk) begin
    if (handler_start === 1'b1) seen[0] = 1'b1;
    if (resume_done === 1'b1) seen[1] = 1'b1;
    if (shutdown_cycle === 1'b1) seen[2] = 1'b1;
    if (invalid_opcode === 1'b1) seen[3] = 1'b1;
    if (restore_valid === 1'b1 && restore_ofs === GPR_A_IMAGE_OFS) got_a = restore_data;
    if (mgmt_irq_n === 1'b0 && cache_flush !== 1'b1) flush_skew++;
  end

  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk32
  task automatic chk1(input string what, input logic exp, input logic got);
    chk32(what, {31'h0, exp}, {31'h0, got});
  endtask : chk1
  task automatic await(input int sel);
    for (int n = 0; n < 1000 && seen[sel] !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    chk1($sformatf("pulse %0d", sel), 1'b1, seen[sel]);
    seen[sel] = 1'b0;
  endtask : await
  task automatic enter(input logic halted);
    @(posedge sys_clk);
    core_halted <= halted;
    mgmt_irq_n <= 1'b0;
    cache_flush <= 1'b1;
    @(posedge sys_clk);
    mgmt_irq_n <= 1'b1;
    cache_flush <= 1'b0;
  endtask : enter
  task automatic resume;
    @(posedge sys_clk);
    opcode_valid <= 1'b1;
    opcode <= RESUME_OPCODE;
    @(posedge sys_clk);
    opcode_valid <= 1'b0;
  endtask : resume
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    wrap_up();
  end

  initial begin
    {rst, mgmt_irq_n, instr_boundary, write_buf_empty, core_halted, nmi, opcode_valid} = 7'b1111000;
    {opcode, wait_cycles, seen, got_a, cache_flush} = '0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk1("active_n", 1'b1, mgmt_active_n);
    chk32("base", 32'h0003_0000, mgmt_base);
    resume();
    await(3);
    $display("reset and stray resume done");
    mem_ctrl_model_i.poke(32'h0003_ffc4, 32'hffff_ffff);
    mem_ctrl_model_i.poke(32'h0003_ffa8, 32'hffff_ffff);
    @(posedge sys_clk);
    write_buf_empty <= 1'b0;
    instr_boundary <= 1'b0;
    enter(1'b1);
    repeat (4) @(posedge sys_clk);
    #1;
    chk1("mode boundary", 1'b0, in_mgmt_mode);
    @(posedge sys_clk);
    instr_boundary <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    chk1("active_n drain", 1'b1, mgmt_active_n);
    chk1("mode drain", 1'b1, in_mgmt_mode);
    @(posedge sys_clk);
    write_buf_empty <= 1'b1;
    await(0);
    chk32("handler", 32'h0003_8000, handler_addr);
    chk1("active_n handler", 1'b0, mgmt_active_n);
    foreach (rows[i]) chk32("slot", rows[i].exp, mem_ctrl_model_i.peek(32'h0003_8000 + {16'h0, rows[i].ofs}));
    chk32("stray", 32'h0, 32'(stray_count));
    $display("save image done");
    mem_ctrl_model_i.poke(32'h0003_ffd0, 32'h1234_5678);
    mem_ctrl_model_i.poke(32'h0003_ff00, 32'h0000_0001);
    mem_ctrl_model_i.poke(32'h0003_fef8, 32'h0004_0000);
    wait_cycles <= 2'h3;
    enter(1'b1);
    resume();
    await(1);
    chk32("gpr a", 32'h1234_5678, got_a);
    chk1("io", 1'b1, io_reexecute);
    chk1("halt", 1'b0, resume_to_halt);
    chk32("base", 32'h0004_0000, mgmt_base);
    chk1("active_n", 1'b1, mgmt_active_n);
    await(0);
    chk32("handler", 32'h0004_8000, handler_addr);
    chk32("top", 32'h05c3_0000, mem_ctrl_model_i.peek(32'h0004_fffc));
    resume();
    await(1);
    chk1("halt", 1'b1, resume_to_halt);
    chk1("io", 1'b0, io_reexecute);
    $display("restore and relocation done");
    for (int k = 0; k < 3; k++) begin
      enter(1'b0);
      await(0);
      mem_ctrl_model_i.poke(32'h0004_fffc, bad_img[k][0]);
      mem_ctrl_model_i.poke(32'h0004_fef8, bad_img[k][1]);
      resume();
      await(2);
      chk1("shut", 1'b1, in_shutdown);
      @(posedge sys_clk);
      nmi <= 1'b1;
      @(posedge sys_clk);
      nmi <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk1("shut nmi", 1'b0, in_shutdown);
    end
    $display("shutdown images done");
    enter(1'b0);
    await(0);
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk1("active_n", 1'b1, mgmt_active_n);
    chk1("mode", 1'b0, in_mgmt_mode);
    chk32("base", 32'h0003_0000, mgmt_base);
    chk32("flush", 32'h0, 32'(flush_skew));
    $display("reset in mode done");
    wrap_up();
  end
endmodule : mgmt_mode_context_save_tb
`default_nettype wire
